// ### plld_pkg.sv
// Shared constants and types of the lock and dead-zone control block.
package plld_pkg;
   // APB register byte offsets.
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CONFIG = 8'h04;
   localparam logic [7:0] ADDR_IF_COUNT = 8'h08;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_INT_MASK = 8'h10;

   // Layout of the latched serial control frame.
   localparam int FRAME_W = 8;
   localparam int FRAME_DZ_LO = 0;
   localparam int FRAME_DZ_HI = 1;
   localparam int FRAME_DLC = 2;
   localparam int FRAME_DOSEL_LO = 3;
   localparam int FRAME_DOSEL_HI = 4;
   localparam int FRAME_CTE = 5;
   localparam int FRAME_GPSEL = 6;
   localparam int FRAME_IFBUF = 7;
   localparam logic [7:0] FRAME_RESET = 8'h00;

   // Interrupt status and mask layout.
   localparam int INT_W = 3;
   localparam int INT_LOCK_GAIN = 0;
   localparam int INT_LOCK_LOST = 1;
   localparam int INT_IF_DONE = 2;
   localparam logic [2:0] INT_MASK_RESET = 3'h0;

   // Widths of the IF counter, the readout shift register and the phase error counter.
   localparam int IF_COUNT_W = 20;
   localparam int READOUT_W = 24;
   localparam int ERR_W = 16;
   localparam logic [15:0] ERR_MAX = 16'hFFFF;

   // Timing.
   localparam int CLOCK_MHZ = 100;
   localparam int IF_GATE_TIME_US = 4000;
   localparam int IF_GATE_CYCLES = IF_GATE_TIME_US * CLOCK_MHZ;
   localparam int PUMP_MIN_NS = 20;
   localparam int PUMP_MIN_CYCLES = (PUMP_MIN_NS * CLOCK_MHZ + 999) / 1000;
   localparam int LOCK_WIN_NS = 30;
   localparam int LOCK_WIN_CYCLES = (LOCK_WIN_NS * CLOCK_MHZ) / 1000;

   // Dead-zone thresholds in clock cycles of phase error.
   localparam logic [15:0] DZ_THR_NARROWEST = 16'h0000;
   localparam logic [15:0] DZ_THR_NARROW = 16'h0001;
   localparam logic [15:0] DZ_THR_GAP = 16'h0003;
   localparam logic [15:0] DZ_THR_WIDE_GAP = 16'h0006;

   typedef enum logic [1:0] {
      pump_on_narrowest = 2'b00,
      pump_on_narrow = 2'b01,
      pump_off_gap = 2'b10,
      pump_off_wide_gap = 2'b11
   } plld_dz_t;

   typedef enum logic [1:0] {
      DO_SERIAL = 2'b00,
      DO_IF_DONE = 2'b01,
      DO_LOCK = 2'b10,
      DO_GP_FOLLOW = 2'b11
   } plld_dosel_t;

   typedef enum logic [1:0] {
      PD_IDLE = 2'b00,
      PD_WAIT_DIV = 2'b01,
      PD_WAIT_REF = 2'b10,
      PD_OUT = 2'b11
   } plld_pd_state_t;
endpackage

// ### plld_sync.sv
// Three-stage input synchroniser with agreement filter and edge pulses.
`timescale 1ns/1ns
module plld_sync (
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_rst_b,
   // Asynchronous input.
   input wire logic i_async,
   // Filtered level and edge pulses.
   output logic o_level,
   output logic o_rise,
   output logic o_fall
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= i_async;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // A change counts once the second and third stages agree.
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_level <= 1'b0;
         o_rise <= 1'b0;
         o_fall <= 1'b0;
      end else begin
         o_rise <= (s2 == s3) && s3 && !o_level;
         o_fall <= (s2 == s3) && !s3 && o_level;
         if (s2 == s3) begin
            o_level <= s3;
         end
      end
   end
endmodule

// ### plld_ctrl.sv
// Lock indication, dead-zone pump control, deadlock clear and IF counter with APB access.
//
// Notes on behaviour
// (RQ1) Lock mode drives output high when locked.
// (RQ2) Controller waits two reference periods after divisor; here lock is decided at every reference rise with no wait.
// (RQ3) Controller confirms lock over consecutive checks; here lock follows a single check at each reference rise.
// (RQ4) Upper dead-zone bit turns the pump off.
// (RQ5) Wide gap exceeds gap; code 00 narrowest.
// (RQ6) Pump-on modes pulse every comparison.
// (RQ7) Output selects data, IF done, or lock.
// (RQ8) Output can follow a general input.
// (RQ9) Deadlock clear forces tuning voltage high.
// (RQ10) Controller counts IF only with station detect; here counting ignores station detect, which only shows in the status register.
// (RQ11) IF counter reset while disabled, starts rising.
// (RQ12) Lock decided once per reference period.
// (RQ13) Settings change only at frame latch.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
module plld_ctrl #(
   parameter int IF_GATE_CYCLES = plld_pkg::IF_GATE_CYCLES
) (
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_rst_b,
   // APB slave.
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Three-wire serial link.
   input wire logic i_link_enable,
   input wire logic i_link_clock,
   input wire logic i_link_data,
   output logic o_link_data_out,
   // Phase comparator.
   input wire logic i_ref_pulse,
   input wire logic i_div_pulse,
   output logic o_pump_up,
   output logic o_pump_down,
   output logic o_tune_force_high,
   // IF counting and general inputs.
   input wire logic i_if_input_pin,
   input wire logic i_station_detect,
   input wire logic [1:0] i_gp_input,
   output logic o_if_buffer_en,
   // Interrupt.
   output logic o_irq
);
   localparam int NSYNC = 9;
   localparam int S_EN = 0;
   localparam int S_CL = 1;
   localparam int S_DI = 2;
   localparam int S_REF = 3;
   localparam int S_DIV = 4;
   localparam int S_IF = 5;
   localparam int S_SD = 6;
   localparam int S_GP0 = 7;

   ////////////////////////////////////////////////////////////////////////////////
   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] lvl;
   logic [NSYNC-1:0] rise;
   logic [NSYNC-1:0] fall;

   assign async_in = {i_gp_input, i_station_detect, i_if_input_pin, i_div_pulse,
                      i_ref_pulse, i_link_data, i_link_clock, i_link_enable};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         plld_sync u_sync (
            .i_clock(i_clock),
            .i_rst_b(i_rst_b),
            .i_async(async_in[gi]),
            .o_level(lvl[gi]),
            .o_rise(rise[gi]),
            .o_fall(fall[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0] shift_in;
   logic [7:0] frame;
   logic [23:0] readout;
   logic lock;
   logic if_done;
   logic if_running;
   logic [19:0] if_count;

   plld_pkg::plld_dz_t dz;
   plld_pkg::plld_dosel_t dosel;
   logic deadlock_clear_bit;
   logic if_count_enable_bit;

   assign dz = plld_pkg::plld_dz_t'(frame[plld_pkg::FRAME_DZ_HI:plld_pkg::FRAME_DZ_LO]);
   assign dosel = plld_pkg::plld_dosel_t'(
      frame[plld_pkg::FRAME_DOSEL_HI:plld_pkg::FRAME_DOSEL_LO]);
   assign deadlock_clear_bit = frame[plld_pkg::FRAME_DLC];
   assign if_count_enable_bit = frame[plld_pkg::FRAME_CTE];

   // Serial bits are shifted in on link clock rises while enabled.
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         shift_in <= plld_pkg::FRAME_RESET;
      end else if (lvl[S_EN] && rise[S_CL]) begin
         shift_in <= {shift_in[6:0], lvl[S_DI]};
      end
   end

   // (RQ13) Latch on enable fall.
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         frame <= plld_pkg::FRAME_RESET;
      end else if (fall[S_EN]) begin
         frame <= shift_in;
      end
   end

   // Readout is loaded at frame start and shifted out on link clock falls.
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         readout <= 24'h000000;
      end else if (rise[S_EN]) begin
         readout <= {lock, if_done, 2'h0, if_count};
      end else if (lvl[S_EN] && fall[S_CL]) begin
         readout <= {readout[22:0], 1'b0};
      end
   end

   // (RQ1) (RQ7) (RQ8) Output pin source selection.
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_link_data_out <= 1'b0;
      end else begin
         case (dosel)
            plld_pkg::DO_SERIAL: o_link_data_out <= readout[23];
            plld_pkg::DO_IF_DONE: o_link_data_out <= if_done;
            plld_pkg::DO_LOCK: o_link_data_out <= lock;
            plld_pkg::DO_GP_FOLLOW: o_link_data_out <= lvl[S_GP0 + int'(frame[plld_pkg::FRAME_GPSEL])];
            default: o_link_data_out <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_if_buffer_en <= 1'b0;
      end else begin
         o_if_buffer_en <= frame[plld_pkg::FRAME_IFBUF];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   logic cte_q;
   logic [19:0] gate_cnt;
   logic if_done_ev;

   // (RQ11) Counter held clear while disabled, started on enable rise.
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         cte_q <= 1'b0;
         if_count <= 20'h00000;
         gate_cnt <= 20'h00000;
         if_running <= 1'b0;
         if_done <= 1'b0;
         if_done_ev <= 1'b0;
      end else begin
         cte_q <= if_count_enable_bit;
         if_done_ev <= 1'b0;
         if (!if_count_enable_bit) begin
            if_count <= 20'h00000;
            gate_cnt <= 20'h00000;
            if_running <= 1'b0;
            if_done <= 1'b0;
         end else if (!cte_q) begin
            if_count <= 20'h00000;
            gate_cnt <= 20'h00000;
            if_running <= 1'b1;
            if_done <= 1'b0;
         end else if (if_running) begin
            if (rise[S_IF]) begin
               if_count <= if_count + 20'h00001;
            end
            gate_cnt <= gate_cnt + 20'h00001;
            if (gate_cnt == 20'(IF_GATE_CYCLES - 1)) begin
               if_running <= 1'b0;
               if_done <= 1'b1;
               if_done_ev <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   plld_pkg::plld_pd_state_t pd_state;
   logic [15:0] err;
   logic lead_ref;
   logic [15:0] both_cnt;
   logic [15:0] lead_cnt;
   logic [15:0] thr;
   logic big_err;

   // (RQ5) Threshold per dead-zone code.
   always_comb begin
      case (dz)
         plld_pkg::pump_on_narrowest: thr = plld_pkg::DZ_THR_NARROWEST;
         plld_pkg::pump_on_narrow: thr = plld_pkg::DZ_THR_NARROW;
         plld_pkg::pump_off_gap: thr = plld_pkg::DZ_THR_GAP;
         plld_pkg::pump_off_wide_gap: thr = plld_pkg::DZ_THR_WIDE_GAP;
         default: thr = plld_pkg::DZ_THR_NARROWEST;
      endcase
   end

   assign big_err = err > thr;

   // Phase error is counted from the leading edge to the lagging edge.
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         pd_state <= plld_pkg::PD_IDLE;
         err <= 16'h0000;
         lead_ref <= 1'b0;
      end else begin
         case (pd_state)
            plld_pkg::PD_IDLE: begin
               err <= 16'h0000;
               if (rise[S_REF] && rise[S_DIV]) begin
                  pd_state <= plld_pkg::PD_OUT;
               end else if (rise[S_REF]) begin
                  lead_ref <= 1'b1;
                  pd_state <= plld_pkg::PD_WAIT_DIV;
               end else if (rise[S_DIV]) begin
                  lead_ref <= 1'b0;
                  pd_state <= plld_pkg::PD_WAIT_REF;
               end
            end
            plld_pkg::PD_WAIT_DIV: begin
               err <= err + 16'h0001;
               if (rise[S_DIV] || err == plld_pkg::ERR_MAX - 16'h0001) begin
                  pd_state <= plld_pkg::PD_OUT;
               end
            end
            plld_pkg::PD_WAIT_REF: begin
               err <= err + 16'h0001;
               if (rise[S_REF] || err == plld_pkg::ERR_MAX - 16'h0001) begin
                  pd_state <= plld_pkg::PD_OUT;
               end
            end
            plld_pkg::PD_OUT: pd_state <= plld_pkg::PD_IDLE;
            default: pd_state <= plld_pkg::PD_IDLE;
         endcase
      end
   end

   // (RQ4) (RQ6) Pump pulses loaded once per comparison.
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         both_cnt <= 16'h0000;
         lead_cnt <= 16'h0000;
      end else if (pd_state == plld_pkg::PD_OUT) begin
         both_cnt <= dz[1] ? 16'h0000 : 16'(plld_pkg::PUMP_MIN_CYCLES);
         lead_cnt <= big_err ? err : 16'h0000;
      end else begin
         if (both_cnt != 16'h0000) begin
            both_cnt <= both_cnt - 16'h0001;
         end
         if (lead_cnt != 16'h0000) begin
            lead_cnt <= lead_cnt - 16'h0001;
         end
      end
   end

   // (RQ9) Deadlock clear overrides the pump.
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_pump_up <= 1'b0;
         o_pump_down <= 1'b0;
         o_tune_force_high <= 1'b0;
      end else begin
         o_tune_force_high <= deadlock_clear_bit;
         o_pump_up <= !deadlock_clear_bit && (both_cnt != 16'h0000 || (lead_cnt != 16'h0000 && lead_ref));
         o_pump_down <= !deadlock_clear_bit && (both_cnt != 16'h0000 || (lead_cnt != 16'h0000 && !lead_ref));
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   logic div_seen;
   logic [15:0] last_err;
   logic lock_gain_ev;
   logic lock_lost_ev;

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         last_err <= plld_pkg::ERR_MAX;
      end else if (pd_state == plld_pkg::PD_OUT) begin
         last_err <= err;
      end
   end

   // (RQ12) One lock decision per reference period.
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         div_seen <= 1'b0;
         lock <= 1'b0;
         lock_gain_ev <= 1'b0;
         lock_lost_ev <= 1'b0;
      end else begin
         lock_gain_ev <= 1'b0;
         lock_lost_ev <= 1'b0;
         if (rise[S_REF]) begin
            div_seen <= rise[S_DIV];
            lock <= div_seen && last_err <= 16'(plld_pkg::LOCK_WIN_CYCLES);
            lock_gain_ev <= !lock && div_seen && last_err <= 16'(plld_pkg::LOCK_WIN_CYCLES);
            lock_lost_ev <= lock && !(div_seen && last_err <= 16'(plld_pkg::LOCK_WIN_CYCLES));
         end else if (rise[S_DIV]) begin
            div_seen <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   logic [2:0] int_status;
   logic [2:0] int_mask;
   logic [2:0] int_ev;
   logic wr_en;
   logic [31:0] next_prdata;
   logic next_pslverr;

   assign int_ev = {if_done_ev, lock_lost_ev, lock_gain_ev};
   assign wr_en = i_psel && i_penable && o_pready && i_pwrite;

   // Sticky status, a new event wins over a write-one clear.
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         int_status <= 3'h0;
      end else begin
         int_status <= (int_status & ~((wr_en && i_paddr == plld_pkg::ADDR_INT_STATUS) ?
                        i_pwdata[2:0] : 3'h0)) | int_ev;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         int_mask <= plld_pkg::INT_MASK_RESET;
      end else if (wr_en && i_paddr == plld_pkg::ADDR_INT_MASK) begin
         int_mask <= i_pwdata[2:0];
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(int_status & int_mask);
      end
   end

   always_comb begin
      next_prdata = 32'h00000000;
      next_pslverr = 1'b0;
      case (i_paddr)
         plld_pkg::ADDR_STATUS: next_prdata = {28'h0000000, lvl[S_SD], if_running, if_done, lock};
         plld_pkg::ADDR_CONFIG: next_prdata = {24'h000000, frame};
         plld_pkg::ADDR_IF_COUNT: next_prdata = {12'h000, if_count};
         plld_pkg::ADDR_INT_STATUS: next_prdata = {29'h00000000, int_status};
         plld_pkg::ADDR_INT_MASK: next_prdata = {29'h00000000, int_mask};
         default: next_pslverr = 1'b1;
      endcase
   end

   // Answer in the first cycle of the access phase, with no wait state.
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h00000000;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= i_psel && !i_penable && !o_pready;
         o_pslverr <= i_psel && !i_penable && !o_pready && next_pslverr;
         if (i_psel && !i_penable && !i_pwrite) begin
            o_prdata <= next_prdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_lock_pin;
      @(posedge i_clock) disable iff (!i_rst_b)
      (dosel == plld_pkg::DO_LOCK && !fall[S_EN]) |=> (o_link_data_out == $past(lock));
   endproperty
   a_lock_pin: assert property (p_lock_pin) else $error("lock pin mismatch"); // RQ1

   property p_pump_off;
      @(posedge i_clock) disable iff (!i_rst_b)
      (pd_state == plld_pkg::PD_OUT && dz[1] && err <= thr) |=>
      (both_cnt == 16'h0000 && lead_cnt == 16'h0000);
   endproperty
   a_pump_off: assert property (p_pump_off) else $error("pump active in dead zone"); // RQ4

   property p_wide_gap;
      @(posedge i_clock) disable iff (!i_rst_b)
      (dz == plld_pkg::pump_off_wide_gap) |-> (thr > plld_pkg::DZ_THR_GAP);
   endproperty
   a_wide_gap: assert property (p_wide_gap) else $error("wide gap not wider"); // RQ5

   property p_pump_on;
      @(posedge i_clock) disable iff (!i_rst_b)
      (pd_state == plld_pkg::PD_OUT && !dz[1] && !deadlock_clear_bit && !fall[S_EN]) ##1 !fall[S_EN] |=>
      (o_pump_up && o_pump_down);
   endproperty
   a_pump_on: assert property (p_pump_on) else $error("no correction pulse"); // RQ6

   property p_do_ifdone;
      @(posedge i_clock) disable iff (!i_rst_b)
      (dosel == plld_pkg::DO_IF_DONE && !fall[S_EN]) |=> (o_link_data_out == $past(if_done));
   endproperty
   a_do_ifdone: assert property (p_do_ifdone) else $error("done flag pin mismatch"); // RQ7

   property p_gp_follow;
      @(posedge i_clock) disable iff (!i_rst_b)
      (dosel == plld_pkg::DO_GP_FOLLOW && !frame[plld_pkg::FRAME_GPSEL] && !fall[S_EN]) |=>
      (o_link_data_out == $past(lvl[S_GP0]));
   endproperty
   a_gp_follow: assert property (p_gp_follow) else $error("input follow mismatch"); // RQ8

   property p_deadlock;
      @(posedge i_clock) disable iff (!i_rst_b)
      (deadlock_clear_bit && !fall[S_EN]) |=> (o_tune_force_high && !o_pump_up && !o_pump_down);
   endproperty
   a_deadlock: assert property (p_deadlock) else $error("deadlock clear not forced"); // RQ9

   property p_if_hold;
      @(posedge i_clock) disable iff (!i_rst_b)
      (!if_count_enable_bit && !fall[S_EN]) |=> (if_count == 20'h00000 && !if_done && !if_running);
   endproperty
   a_if_hold: assert property (p_if_hold) else $error("counter not held"); // RQ11

   property p_lock_period;
      @(posedge i_clock) disable iff (!i_rst_b)
      !$stable(lock) |-> $past(rise[S_REF]);
   endproperty
   a_lock_period: assert property (p_lock_period) else $error("lock changed mid period"); // RQ12

   property p_frame_hold;
      @(posedge i_clock) disable iff (!i_rst_b)
      !fall[S_EN] |=> $stable(frame);
   endproperty
   a_frame_hold: assert property (p_frame_hold) else $error("settings changed while shifting"); // RQ13
endmodule

// ### plld_mcu_model.sv
// Behavioural system controller on the three-wire serial control link.
`timescale 1ns/1ns
module plld_mcu_model (
   // Clock.
   input wire logic i_clock,
   // Output pin of the block.
   input wire logic i_link_data_out,
   // Serial link drive.
   output logic o_link_enable,
   output logic o_link_clock,
   output logic o_link_data
);
   initial begin
      o_link_enable = 1'b0;
      o_link_clock = 1'b0;
      o_link_data = 1'b0;
   end
   // Sends one frame MSB first; the link clock stands low outside frames.
   // Low phases alternate 7 and 6 cycles so the mean period is 125 ns.
   task automatic send_frame(input logic [7:0] frame);
      @(posedge i_clock);
      o_link_enable <= 1'b1;
      for (int i = 7; i >= 0; i--) begin
         o_link_data <= frame[i];
         repeat (6 + i % 2) @(posedge i_clock);
         o_link_clock <= 1'b1;
         repeat (6) @(posedge i_clock);
         o_link_clock <= 1'b0;
      end
      repeat (6) @(posedge i_clock);
      o_link_enable <= 1'b0;
      // A released data line shows the inverse of its last bit.
      o_link_data <= ~frame[0];
      repeat (12) @(posedge i_clock);
   endtask
   // consecutive lock checks.
   // Samples the pin twice a gap apart and gives an unknown if they disagree.
   task automatic sample_pin(input int gap, output logic level);
      logic first;
      // Sampling away from the rising edge sees the pin settled.
      @(negedge i_clock);
      first = i_link_data_out;
      repeat (gap) @(negedge i_clock);
      level = (first === i_link_data_out) ? first : 1'bx;
   endtask
endmodule

// ### testbench.sv
// Self-checking testbench of the lock and dead-zone control block.
`timescale 1ns/1ns
module testbench;
   logic i_clock, i_rst_b, i_psel, i_penable, i_pwrite, err, lvl;
   logic [7:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, rd;
   logic [31:0] seed = 32'h000177AD;
   logic o_pready, o_pslverr, link_en, link_clk, link_dat, o_link_data_out;
   logic i_ref_pulse, i_div_pulse, o_pump_up, o_pump_down, o_tune_force_high;
   logic i_if_input_pin, i_station_detect, o_if_buffer_en, o_irq;
   logic [1:0] i_gp_input;
   logic [7:0] frames[$];
   int miscompares = 0;
   int n_tests = 0;
   int cycles = 0;
   int up_n = 0;
   int dn_n = 0;
   int exp_int = 0;

   plld_ctrl #(.IF_GATE_CYCLES(200)) i_plld_ctrl (
      .i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .i_link_enable(link_en),
      .i_link_clock(link_clk), .i_link_data(link_dat), .o_link_data_out(o_link_data_out),
      .i_ref_pulse(i_ref_pulse), .i_div_pulse(i_div_pulse), .o_pump_up(o_pump_up),
      .o_pump_down(o_pump_down), .o_tune_force_high(o_tune_force_high),
      .i_if_input_pin(i_if_input_pin), .i_station_detect(i_station_detect),
      .i_gp_input(i_gp_input), .o_if_buffer_en(o_if_buffer_en), .o_irq(o_irq));
   plld_mcu_model i_plld_mcu_model (
      .i_clock(i_clock), .i_link_data_out(o_link_data_out), .o_link_enable(link_en),
      .o_link_clock(link_clk), .o_link_data(link_dat));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      cycles++;
      up_n += o_pump_up;
      dn_n += o_pump_down;
      if (cycles == 30000) begin
         miscompares++;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge i_clock);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clock);
      i_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clock);
         n++;
      end while (o_pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         finish_test();
      end
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   // Sends a frame and compares the latched copy with the newest entry of the frame history.
   task automatic send(input logic [7:0] f);
      frames.push_back(f);
      i_plld_mcu_model.send_frame(f);
      apb(1'b0, plld_pkg::ADDR_CONFIG, 32'h0);
      check(rd, {24'h0, frames[$]});
   endtask
   task automatic pulses(input int n, input int e, input logic div_on);
      for (int k = 0; k < n * 40; k++) begin
         i_ref_pulse <= (k % 40) < 10;
         i_div_pulse <= div_on && (k % 40) >= e && (k % 40) < e + 10;
         @(posedge i_clock);
      end
      i_ref_pulse <= 1'b0;
      i_div_pulse <= 1'b0;
   endtask
   task automatic int_check(input int set_bits, input logic irq);
      exp_int |= set_bits;
      apb(1'b0, plld_pkg::ADDR_INT_STATUS, 32'h0);
      check(rd, exp_int);
      check(o_irq, irq);
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      i_rst_b = 1'b0;
      {i_psel, i_penable, i_pwrite, i_ref_pulse, i_div_pulse} = 5'h00;
      {i_if_input_pin, i_station_detect, i_gp_input} = 4'h0;
      i_paddr = 8'h00;
      i_pwdata = 32'h0;
      repeat (4) @(posedge i_clock);
      i_rst_b <= 1'b1;
      apb(1'b0, plld_pkg::ADDR_INT_MASK, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      check(rd, 32'h0);
      check(err, 1'b1);
      apb(1'b1, plld_pkg::ADDR_CONFIG, 32'h000000FF);
      apb(1'b0, plld_pkg::ADDR_CONFIG, 32'h0);
      check(rd, 32'h0);
      fork
         send(8'h04);
         begin
            repeat (60) @(posedge i_clock);
            check(o_tune_force_high, 1'b0);
         end
      join
      check(o_tune_force_high, 1'b1);
      for (int dz = 0; dz < 4; dz++) begin
         send(8'(dz));
         up_n = 0;
         dn_n = 0;
         pulses(3, 5, 1'b1);
         repeat (20) @(posedge i_clock);
         check(dn_n > 0, dz < 2);
         check(up_n > 0, dz != 3);
      end
      check(o_tune_force_high, 1'b0);
      apb(1'b1, plld_pkg::ADDR_INT_MASK, 32'h1);
      send(8'h10);
      // four reference periods pass before the pin is trusted.
      pulses(4, 1, 1'b1);
      i_plld_mcu_model.sample_pin(20, lvl);
      check(lvl, 1'b1);
      int_check(1, 1'b1);
      apb(1'b1, plld_pkg::ADDR_INT_STATUS, 32'h1);
      exp_int = 0;
      pulses(3, 1, 1'b0);
      i_plld_mcu_model.sample_pin(20, lvl);
      check(lvl, 1'b0);
      int_check(2, 1'b0);
      apb(1'b1, plld_pkg::ADDR_INT_MASK, 32'h2);
      repeat (3) @(posedge i_clock);
      check(o_irq, 1'b1);
      apb(1'b1, plld_pkg::ADDR_INT_STATUS, 32'h2);
      exp_int = 0;
      int_check(0, 1'b0);
      for (int g = 0; g < 2; g++) begin
         send(8'h18 | 8'(g << 6));
         repeat (3) begin
            seed = lfsr(seed);
            i_gp_input <= seed[1:0];
            repeat (8) @(posedge i_clock);
            check(o_link_data_out, seed[g]);
         end
      end
      i_station_detect <= 1'b1;
      send(8'hA8);
      repeat (10) begin
         i_if_input_pin <= 1'b1;
         repeat (4) @(posedge i_clock);
         i_if_input_pin <= 1'b0;
         repeat (4) @(posedge i_clock);
      end
      for (int k = 0; k < 400 && o_link_data_out !== 1'b1; k++) @(posedge i_clock);
      check(o_link_data_out, 1'b1);
      check(o_if_buffer_en, 1'b1);
      // result read before the enable is cleared.
      apb(1'b0, plld_pkg::ADDR_IF_COUNT, 32'h0);
      check(rd, 32'h0000000A);
      apb(1'b0, plld_pkg::ADDR_STATUS, 32'h0);
      check(rd, 32'hA);
      int_check(4, 1'b0);
      send(8'h08);
      check(o_link_data_out, 1'b0);
      apb(1'b0, plld_pkg::ADDR_IF_COUNT, 32'h0);
      check(rd, 32'h0);
      finish_test();
   end
endmodule
